//--- core/codec_serial_pkg.sv
// Shared constants and types for the codec serial port
package codec_serial_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] TXDATA_OFS = 8'h08;
   localparam logic [7:0] RXDATA_OFS = 8'h0c;
   // Control field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_W = 6;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   // Status field positions
   localparam int ST_TX_FULL = 0;
   localparam int ST_TX_EMPTY = 1;
   localparam int ST_RX_VALID = 2;
   localparam int ST_RX_FULL = 3;
   localparam int ST_UNDERRUN = 4;
   localparam int ST_OVERRUN = 5;
   // Sample and slot geometry
   localparam int SAMPLE_W = 16;
   localparam int RX_WORD_W = 17;
   localparam logic [8:0] NARROW_BITS = 9'h008;
   localparam logic [8:0] WIDE_BITS = 9'h010;
   localparam logic [8:0] POS_IDLE = 9'h1ff;
   // Master bit clock timing
   localparam int PCLK_KHZ = 250000;
   localparam int MASTER_BCLK_KHZ = 2048;
   localparam int SAMPLE_RATE_HZ = 8000;
   localparam int BCLK_HALF_CYCLES = PCLK_KHZ / (2 * MASTER_BCLK_KHZ);
   localparam int FRAME_LEN_BITS = (MASTER_BCLK_KHZ * 1000) / SAMPLE_RATE_HZ;
   // Configuration word, high bit first
   typedef struct packed {
      logic two_syncs;   // Second codec slot and second frame sync used
      logic double_rate; // Slave: incoming bit clock halved
      logic long_frame;  // Long frame protocol
      logic width16;     // 16-bit channels
      logic master;      // Device drives bit clock and first sync
      logic enable;      // Link running
   } cfg_t;
endpackage : codec_serial_pkg

//--- core/codec_sync2.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module codec_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Asynchronous inputs and synchronised outputs
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta; // First stage, read only by q

   // Two stages in series
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : codec_sync2

//--- core/codec_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module codec_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH]; // Storage
   logic [AW:0] wr_ptr; // Write pointer with wrap bit
   logic [AW:0] rd_ptr; // Read pointer with wrap bit
   logic [AW:0] fill; // Words held
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   assign fill = wr_ptr - rd_ptr;
   assign in_ready = (fill != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign out_valid = (fill != '0);
   assign out_data = mem[rd_ptr[AW-1:0]];

   // Pointer update
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
      end
   end

   // Storage write, no reset needed
   always_ff @(posedge clk) begin
      if (push) mem[wr_ptr[AW-1:0]] <= in_data;
   end
endmodule : codec_fifo

//--- core/codec_serial_interface.sv
// Codec serial port: APB registers, bit clock, frame syncs and shifters
`timescale 1ns/10ps
module codec_serial_interface
   import codec_serial_pkg::*;
#(
   parameter int HALF_DIV = BCLK_HALF_CYCLES,
   parameter int FRAME_BITS = FRAME_LEN_BITS,
   parameter int FIFO_DEPTH = 4
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Bit clock pin
   input wire logic codec_bit_clock_in,
   output logic codec_bit_clock_out,
   output logic codec_bit_clock_oe,
   // First frame sync pin
   input wire logic frame_sync_first_in,
   output logic frame_sync_first_out,
   output logic frame_sync_first_oe,
   // Second frame sync and data pins
   output logic frame_sync_second,
   output logic codec_serial_tx,
   input wire logic codec_serial_rx
);
   cfg_t cfg; // Link configuration
   logic underrun; // Sticky: slot started with no transmit word
   logic overrun; // Sticky: received word lost, receive FIFO full

   // APB decode
   wire setup = psel & ~penable;
   wire access = psel & penable;
   wire sel_ctrl = (paddr == CTRL_OFS);
   wire sel_status = (paddr == STATUS_OFS);
   wire sel_tx = (paddr == TXDATA_OFS);
   wire sel_rx = (paddr == RXDATA_OFS);
   wire mapped = sel_ctrl | sel_status | sel_tx | sel_rx;

   // FIFO handshakes
   logic tx_in_ready; // Transmit FIFO has room
   logic tx_out_valid; // Transmit word available
   logic tx_out_ready; // Slot load takes a word
   logic [SAMPLE_W-1:0] tx_word; // Head of transmit FIFO
   logic rx_in_valid; // Received word complete
   logic rx_in_ready; // Receive FIFO has room
   logic rx_out_valid; // Received word waiting
   logic [RX_WORD_W-1:0] rx_word; // Head of receive FIFO
   logic [RX_WORD_W-1:0] rx_push_data; // Word being stored

   // A transmit write waits while the FIFO is full
   assign pready = ~(sel_tx & pwrite & ~tx_in_ready);
   assign pslverr = access & ~mapped;
   wire done = access & pready;
   wire wr_done = done & pwrite & mapped;
   wire tx_push = access & pwrite & sel_tx;
   wire rx_pop = done & ~pwrite & sel_rx;

   // Read data selection
   wire [31:0] status_word = {26'h0000000, overrun, underrun, ~rx_in_ready, rx_out_valid,
                              ~tx_out_valid, ~tx_in_ready};
   wire [31:0] read_mux = sel_ctrl ? {26'h0000000, cfg} :
                          sel_status ? status_word :
                          sel_rx ? {15'h0000, rx_word} : 32'h00000000;

   // Read data latched in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= 32'h00000000;
      else if (setup & ~pwrite) prdata <= read_mux;
   end

   // Configuration: while enabled only the enable bit may change
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= cfg_t'(CTRL_RESET);
      end else if (wr_done & sel_ctrl) begin
         if (cfg.enable) cfg.enable <= pwdata[CTRL_EN_BIT];
         else cfg <= cfg_t'(pwdata[CTRL_W-1:0]);
      end
   end

   // Pin synchronisers
   logic bclk_s; // Synchronised incoming bit clock
   logic fs0_s; // Synchronised first frame sync
   logic rx_s; // Synchronised receive data
   codec_sync2 #(.W(3)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({codec_bit_clock_in, frame_sync_first_in, codec_serial_rx}),
      .q({bclk_s, fs0_s, rx_s})
   );

   // Pin directions follow the mode
   assign codec_bit_clock_oe = cfg.master;
   assign frame_sync_first_oe = cfg.master;

   // Master bit clock divider
   logic [7:0] div_cnt; // Half-period counter
   logic bclk_gen; // Generated bit clock
   wire run_master = cfg.enable & cfg.master;
   wire div_wrap = run_master & (div_cnt == 8'(HALF_DIV - 1));
   wire m_rise = div_wrap & ~bclk_gen;
   wire m_fall = div_wrap & bclk_gen;
   assign codec_bit_clock_out = bclk_gen;

   // Divider runs only in master mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt <= 8'h00;
         bclk_gen <= 1'b0;
      end else if (!run_master) begin
         div_cnt <= 8'h00;
         bclk_gen <= 1'b0;
      end else if (div_wrap) begin
         div_cnt <= 8'h00;
         bclk_gen <= ~bclk_gen;
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end

   // Slave edge detection on the synchronised clock
   logic bclk_prev; // Previous synchronised clock
   logic halve; // Halved clock phase in double rate
   wire s_edge = bclk_s & ~bclk_prev;
   wire s_fedge = ~bclk_s & bclk_prev;
   wire run_slave = cfg.enable & ~cfg.master;
   wire s_rise = cfg.double_rate ? (s_edge & ~halve) : s_edge;
   wire s_fall = cfg.double_rate ? (s_edge & halve) : s_fedge;

   // Edge history and divide-by-two phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bclk_prev <= 1'b0;
         halve <= 1'b0;
      end else begin
         bclk_prev <= bclk_s;
         if (!run_slave) halve <= 1'b0;
         else if (s_edge) halve <= ~halve;
      end
   end

   // Bit-period ticks common to both modes
   wire rise_tick = cfg.master ? m_rise : (run_slave & s_rise);
   wire fall_tick = cfg.master ? m_fall : (run_slave & s_fall);

   // Frame position, advanced at each bit-clock rise
   logic [8:0] pos; // Current bit index in frame
   logic fs0_last; // First sync seen at previous rise
   logic [8:0] next_pos; // Position for the coming bit
   wire slave_start = fs0_s & ~fs0_last;
   wire [8:0] frame_last = 9'(FRAME_BITS - 1);

   // Master wraps each frame; slave restarts on the sync edge
   always_comb begin
      if (cfg.master) next_pos = (pos >= frame_last) ? 9'h000 : pos + 9'h001;
      else if (slave_start) next_pos = 9'h000;
      else next_pos = (pos == POS_IDLE) ? POS_IDLE : pos + 9'h001;
   end

   // Slot geometry for the coming bit
   wire [8:0] w = cfg.width16 ? WIDE_BITS : NARROW_BITS;
   wire [8:0] d0 = cfg.long_frame ? 9'h000 : 9'h001;
   wire [8:0] d1 = cfg.long_frame ? w : w + 9'h002;
   wire in_slot0 = (next_pos >= d0) & (next_pos < d0 + w);
   wire in_slot1 = cfg.two_syncs & (next_pos >= d1) & (next_pos < d1 + w);
   wire load0 = (next_pos == d0);
   wire load1 = cfg.two_syncs & (next_pos == d1);
   wire slot_load = load0 | load1;
   wire fs0_short = (next_pos == 9'h000);
   wire fs0_long = (next_pos < w);
   wire fs0_level = cfg.long_frame ? fs0_long : fs0_short;
   wire fs1_short = (next_pos == w + 9'h001);
   wire fs1_long = (next_pos >= w) & (next_pos < w + w);
   wire fs1_level = cfg.two_syncs & (cfg.long_frame ? fs1_long : fs1_short);

   // A slot load takes one word from the transmit FIFO
   assign tx_out_ready = rise_tick & slot_load;
   wire [SAMPLE_W-1:0] tx_src = tx_out_valid ? tx_word : 16'h0000;
   wire [SAMPLE_W-1:0] tx_aligned = cfg.width16 ? tx_src : {tx_src[7:0], 8'h00};

   // Transmit side and frame syncs, updated at each rise
   logic [SAMPLE_W-1:0] tx_shift; // Outgoing sample
   logic slot_active; // A slot is in progress
   logic slot_id; // Slot 1 belongs to the second codec
   logic [4:0] rx_cnt; // Bits received in this slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos <= POS_IDLE;
         fs0_last <= 1'b0;
         frame_sync_first_out <= 1'b0;
         frame_sync_second <= 1'b0;
         tx_shift <= 16'h0000;
         slot_active <= 1'b0;
         slot_id <= 1'b0;
      end else if (!cfg.enable) begin
         pos <= POS_IDLE;
         fs0_last <= 1'b0;
         frame_sync_first_out <= 1'b0;
         frame_sync_second <= 1'b0;
         tx_shift <= 16'h0000;
         slot_active <= 1'b0;
      end else if (rise_tick) begin
         pos <= next_pos;
         fs0_last <= fs0_s;
         frame_sync_first_out <= cfg.master & fs0_level;
         frame_sync_second <= fs1_level;
         slot_active <= in_slot0 | in_slot1;
         if (slot_load) begin
            tx_shift <= tx_aligned;
            slot_id <= load1;
         end else if (in_slot0 | in_slot1) begin
            tx_shift <= {tx_shift[SAMPLE_W-2:0], 1'b0};
         end else begin
            tx_shift <= 16'h0000;
         end
      end
   end

   // Outgoing bit is the top of the shifter
   assign codec_serial_tx = tx_shift[SAMPLE_W-1];

   // Receive side, sampled at each fall within a slot
   logic [SAMPLE_W-1:0] rx_shift; // Incoming sample
   wire [SAMPLE_W-1:0] rx_next = {rx_shift[SAMPLE_W-2:0], rx_s};
   wire rx_last = (rx_cnt == 5'(w - 9'h001));
   assign rx_in_valid = fall_tick & slot_active & rx_last;
   assign rx_push_data = {slot_id, cfg.width16 ? rx_next : {8'h00, rx_next[7:0]}};

   // Receive shifter and bit count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_shift <= 16'h0000;
         rx_cnt <= 5'h00;
      end else if (rise_tick & slot_load) begin
         rx_cnt <= 5'h00;
      end else if (fall_tick & slot_active) begin
         rx_shift <= rx_next;
         rx_cnt <= rx_last ? 5'h00 : rx_cnt + 5'h01;
      end
   end

   // Sticky errors: an event in the clearing cycle wins
   wire clr_st = wr_done & sel_status;
   wire set_under = tx_out_ready & ~tx_out_valid;
   wire set_over = rx_in_valid & ~rx_in_ready;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         underrun <= 1'b0;
         overrun <= 1'b0;
      end else begin
         if (set_under) underrun <= 1'b1;
         else if (clr_st & pwdata[ST_UNDERRUN]) underrun <= 1'b0;
         if (set_over) overrun <= 1'b1;
         else if (clr_st & pwdata[ST_OVERRUN]) overrun <= 1'b0;
      end
   end

   // Transmit samples from software to the slot loader
   codec_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .clk(pclk),
      .rst_n(presetn),
      .in_valid(tx_push),
      .in_ready(tx_in_ready),
      .in_data(pwdata[SAMPLE_W-1:0]),
      .out_valid(tx_out_valid),
      .out_ready(tx_out_ready),
      .out_data(tx_word)
   );

   // Received samples from the shifter to software
   codec_fifo #(.WIDTH(RX_WORD_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .clk(pclk),
      .rst_n(presetn),
      .in_valid(rx_in_valid),
      .in_ready(rx_in_ready),
      .in_data(rx_push_data),
      .out_valid(rx_out_valid),
      .out_ready(rx_pop),
      .out_data(rx_word)
   );
endmodule : codec_serial_interface

//--- sim/codec_serial_chk_sva.sv
// Checker for codec port pin timing and bus answers
`timescale 1ns/10ps
module codec_serial_chk
   import codec_serial_pkg::*;
#(
   parameter int HALF_DIV = BCLK_HALF_CYCLES
) (
   // Clock, reset and bus
   input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   // Link pins
   input wire logic codec_bit_clock_out, codec_bit_clock_oe, frame_sync_first_out,
   input wire logic frame_sync_first_oe, frame_sync_second, codec_serial_tx
);
   localparam int BP = 2 * HALF_DIV; // Pclk cycles per bit
   cfg_t cfg; // Shadow of the control word
   int hi1, hi2, since; // Sync high times, cycles since first sync rose
   logic fs1_q; // First sync one cycle back
   wire logic [4:0] w = cfg.width16 ? 5'h10 : 5'h08; // Channel bits
   wire logic hit = psel && penable && pready; // Transfer taken
   wire logic mapped = paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0; // Known place
   // Follow control writes; only enable moves while running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cfg <= CTRL_RESET;
      else if (hit && pwrite && paddr == CTRL_OFS)
         cfg <= cfg.enable ? {cfg[5:1], pwdata[0]} : pwdata[5:0];
   end
   // Sync high times and spacing of the two syncs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi1 <= 0;
         hi2 <= 0;
         since <= 0;
         fs1_q <= 1'b0;
      end else begin
         hi1 <= frame_sync_first_out ? hi1 + 1 : 0;
         hi2 <= frame_sync_second ? hi2 + 1 : 0;
         since <= (frame_sync_first_out && !fs1_q) ? 1 : since + 1;
         fs1_q <= frame_sync_first_out;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_oe_pair;
      codec_bit_clock_oe == frame_sync_first_oe &&
      (codec_bit_clock_oe || !codec_bit_clock_out && !frame_sync_first_out);
   endproperty
   a_oe_pair: assert property (p_oe_pair)
      else $error("pin direction wrong");
   property p_off_quiet;
      !cfg.enable ##1 !cfg.enable |-> !codec_serial_tx && !frame_sync_second &&
      !codec_bit_clock_out;
   endproperty
   a_off_quiet: assert property (p_off_quiet)
      else $error("link active while disabled");
   property p_fs1_width;
      $fell(frame_sync_first_out) && codec_bit_clock_out && frame_sync_first_oe |->
      hi1 == (cfg.long_frame ? w * BP : BP);
   endproperty
   a_fs1_width: assert property (p_fs1_width)
      else $error("first sync width wrong");
   property p_fs2_width;
      $fell(frame_sync_second) && codec_bit_clock_out && codec_bit_clock_oe |->
      hi2 == (cfg.long_frame ? w * BP : BP);
   endproperty
   a_fs2_width: assert property (p_fs2_width)
      else $error("second sync width wrong");
   property p_fs2_place;
      $rose(frame_sync_second) && codec_bit_clock_oe |->
      since == (cfg.long_frame ? w : w + 1) * BP;
   endproperty
   a_fs2_place: assert property (p_fs2_place)
      else $error("second sync misplaced");
   property p_one_sync;
      !cfg.two_syncs |-> !frame_sync_second;
   endproperty
   a_one_sync: assert property (p_one_sync)
      else $error("second sync without second slot");
   property p_tx_at_rise;
      $changed(codec_serial_tx) && cfg.enable && codec_bit_clock_oe |->
      $rose(codec_bit_clock_out);
   endproperty
   a_tx_at_rise: assert property (p_tx_at_rise)
      else $error("data changed off the bit clock");
   property p_err;
      psel && penable |-> pslverr == !mapped && (pready || pwrite);
   endproperty
   a_err: assert property (p_err)
      else $error("bus error answer wrong");
   c_two: cover property ($rose(frame_sync_second));
   c_wait: cover property (psel && penable && !pready);
   c_bad: cover property (pslverr);
endmodule : codec_serial_chk
bind codec_serial_interface codec_serial_chk #(.HALF_DIV(HALF_DIV)) codec_serial_chk_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
   .codec_bit_clock_out(codec_bit_clock_out), .codec_bit_clock_oe(codec_bit_clock_oe),
   .frame_sync_first_out(frame_sync_first_out), .frame_sync_first_oe(frame_sync_first_oe),
   .frame_sync_second(frame_sync_second), .codec_serial_tx(codec_serial_tx));

//--- sim/codec_serial_partner.sv
// Behavioural voice codec and telephony line source
`timescale 1ns/10ps
module codec_serial_partner #(
   parameter logic [15:0] REPLY = 16'hc35a
) (
   // Clock and mode
   input wire logic pclk, slave_en, wide,
   // Board side of the link pins
   input wire logic bclk, fs_a, fs_b, tx_in,
   output logic bclk_src, fs_src, rx_out,
   // Last whole slot heard from the device
   output logic [15:0] heard
);
   int cnt = 99; // Bit index inside a slot
   int rises = 0; // Line clock rises so far
   logic [15:0] sh = 16'h0; // Device data shifter
   logic [1:0] fs_q = 2'b00; // Sync levels at the previous falling edge
   logic sync_tog = 1'b0; // Flips at each sync rising edge seen mid-bit
   logic seen_tog = 1'b0; // Last flip taken up by the answer side
   // Line source: free clock near 3.9 MHz, first sync two bits long
   initial begin
      bclk_src = 1'b0;
      fs_src = 1'b0;
      rx_out = 1'b0;
      heard = 16'h0;
      forever begin
         repeat (32) @(posedge pclk);
         bclk_src <= slave_en && !bclk_src;
         if (!bclk_src)
            rises++;
         fs_src <= slave_en && (rises % 100 < 2);
      end
   end
   // Answer after each sync, most significant bit first
   always @(posedge bclk) begin
      if (sync_tog != seen_tog) begin
         seen_tog <= sync_tog;
         rx_out <= REPLY[wide ? 15 : 7];
         cnt <= 1;
      end else if (cnt < (wide ? 16 : 8)) begin
         rx_out <= REPLY[(wide ? 15 : 7) - cnt];
         cnt <= cnt + 1;
      end else begin
         rx_out <= ~rx_out; // Released line keeps no stale level
         cnt <= 99;
      end
   end
   // Take device data and syncs mid-bit, clear of the edge that launches them
   always @(negedge bclk) begin
      fs_q <= {fs_a, fs_b};
      if ((fs_a && !fs_q[1]) || (fs_b && !fs_q[0]))
         sync_tog <= ~sync_tog;
      if (cnt >= 1 && cnt <= (wide ? 16 : 8)) begin
         sh = {sh[14:0], tx_in};
         if (cnt == (wide ? 16 : 8))
            heard = sh;
      end
   end
endmodule : codec_serial_partner

//--- sim/test_codec_serial_interface.sv
// Self-checking bench for the codec serial port
`timescale 1ns/10ps
module test_codec_serial_interface;
   import codec_serial_pkg::*;
   localparam logic [15:0] REPLY = 16'hc35a; // Codec answer word
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic pready, pslverr, err, wide = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic ck_o, ck_oe, f1_o, f1_oe, fs2, tx, rx, ck_s, f1_s;
   logic [15:0] heard;
   logic [15:0] words [5] = '{16'h8001, 16'h1234, 16'h00ff, 16'hff00, 16'h5aa5};
   logic [31:0] modes [4] = '{32'h2b, 32'h2f, 32'h21, 32'h39}; // Link setups
   int fail_count = 0;
   int n_compared = 0;
   int n2 = 0; // Second sync pulses
   wire logic ck = ck_oe ? ck_o : ck_s; // Bit clock wire
   wire logic f1 = f1_oe ? f1_o : f1_s; // First sync wire
   codec_serial_interface #(.HALF_DIV(4), .FRAME_BITS(48)) codec_serial_interface_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .codec_bit_clock_in(ck), .codec_bit_clock_out(ck_o), .codec_bit_clock_oe(ck_oe),
      .frame_sync_first_in(f1), .frame_sync_first_out(f1_o), .frame_sync_first_oe(f1_oe),
      .frame_sync_second(fs2), .codec_serial_tx(tx), .codec_serial_rx(rx));
   codec_serial_partner #(.REPLY(REPLY)) codec_serial_partner_inst (.pclk(pclk),
      .slave_en(!ck_oe), .wide(wide), .bclk(ck), .fs_a(f1), .fs_b(fs2), .tx_in(tx),
      .bclk_src(ck_s), .fs_src(f1_s), .rx_out(rx), .heard(heard));
   // 250 MHz clock
   initial begin
      forever #2 pclk = ~pclk;
   end
   always @(posedge fs2) n2++;
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("unexpected at %0t: want %h got %h", $time, exp, got);
         fail_count++;
      end
   endtask : chk
   task automatic close_out();
      $display("compared %0d, mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   // One bus transfer, held until the slave answers
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 400);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 400) begin
         fail_count++;
         close_out();
      end
      @(posedge pclk);
   endtask : apb
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(exp, rd);
   endtask : rd_chk
   // Poll until a received word waits
   task automatic wait_rx();
      int n;
      n = 0;
      do begin
         apb(1'b0, STATUS_OFS, 32'h0);
         n++;
      end while (rd[ST_RX_VALID] !== 1'b1 && n < 200);
      chk(32'h1, {31'h0, rd[ST_RX_VALID]});
   endtask : wait_rx
   initial begin
      int k;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk(CTRL_OFS, 32'h0);
      rd_chk(STATUS_OFS, 32'h2);
      apb(1'b0, 8'h10, 32'h0);
      chk(32'h1, {31'h0, err});
      $display("test reset done");
      for (int i = 0; i < 4; i++)
         apb(1'b1, TXDATA_OFS, {16'h0, words[i]});
      rd_chk(STATUS_OFS, 32'h1);
      apb(1'b1, CTRL_OFS, 32'h27);
      apb(1'b1, TXDATA_OFS, {16'h0, words[4]});
      apb(1'b1, CTRL_OFS, 32'h1);
      rd_chk(CTRL_OFS, 32'h27);
      for (int i = 0; i < 4; i++) begin
         wait_rx();
         chk({16'h0, words[i]}, {16'h0, heard});
         rd_chk(RXDATA_OFS, {15'h0, i[0], REPLY});
      end
      $display("test master exchange done");
      repeat (1200) @(posedge pclk);
      rd_chk(STATUS_OFS, 32'h3e);
      apb(1'b1, CTRL_OFS, 32'h26);
      apb(1'b1, STATUS_OFS, 32'h30);
      rd_chk(STATUS_OFS, 32'h0e);
      $display("test fifo limits done");
      foreach (modes[m]) begin
         wide <= modes[m][2];
         apb(1'b1, CTRL_OFS, modes[m]);
         k = n2;
         repeat (13000) @(posedge pclk);
         chk({31'h0, modes[m][1]}, {31'h0, ck_oe});
         chk(32'h1, {31'h0, n2 > k});
         apb(1'b1, CTRL_OFS, 32'h0);
      end
      $display("test link modes done");
      close_out();
   end
endmodule : test_codec_serial_interface
